// *** verilog/sch_consts.svh ***
// Operation
// - Hold selected core inputs deasserted before hand-off.
// - After hand-off, pass user inputs through.
// - Answer unhandled requests with Unsupported Request beforehand.
// - After hand-off, forward such requests to user.
// - Hand-off indicator low until second stage loaded.
// - End-of-startup output mirrors startup indication.
// - Drive configuration-port request output.
// - Accept release-request input from outside.
// - Reset output tracks core reset, user clock.
// - Supply clock output for interfacing logic.
// - Link-up output high while link established.
// - Request raised, granted, release asked, request dropped.
// - Hand-off low isolates core, returns Unsupported Request.
// - Startup output low, high, high across stages.
`ifndef SCH_CONSTS_SVH
`define SCH_CONSTS_SVH
`define SCH_CTRL_W 4
`define SCH_CTRL_IDLE 4'h0
`define SCH_RST_VAL 1'b1
`define SCH_SYNC_BITS 3
`define SCH_PIN_EOS 0
`define SCH_PIN_DONE 1
`define SCH_PIN_LNK 2
`endif

// *** verilog/sch_pkg.sv ***
`default_nettype none
`include "sch_consts.svh"
package sch_pkg;
	typedef struct packed {
		logic [`SCH_CTRL_W-1:0] ctrl;
	} sch_ctrl_t;
	typedef struct packed {
		logic valid;
		logic unhandled;
	} sch_req_t;
	typedef struct packed {
		logic fwd;
		logic ur;
	} sch_resp_t;
	typedef enum logic [1:0] {
		SCH_IDLE = 2'b00,
		SCH_REQ = 2'b01,
		SCH_OWN = 2'b11,
		SCH_DROP = 2'b10
	} sch_arb_t;
endpackage : sch_pkg
`default_nettype wire

// *** verilog/sch_handoff.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sch_consts.svh"
module sch_handoff (
	input wire logic clock,
	input wire logic rst,
	input wire logic eos_in,
	input wire logic stage2_done,
	input wire logic link_up_in,
	input wire logic cfg_want,
	input wire logic cap_grant,
	input wire logic cap_release,
	input wire sch_pkg::sch_ctrl_t user_ctrl,
	input wire sch_pkg::sch_req_t rx_req,
	output logic user_clk,
	output logic user_reset,
	output logic user_link_up,
	output logic design_switch,
	output logic eos_out,
	output logic cap_request,
	output sch_pkg::sch_ctrl_t core_ctrl,
	output sch_pkg::sch_resp_t rx_resp
);
	import sch_pkg::*;

	// The three slow pins arrive from outside the clock domain.
	// Each of them passes two flip-flops before any logic reads it.
	// Only the second stage of each synchroniser is read by the logic below.
	logic [`SCH_SYNC_BITS-1:0] pin_raw;
	logic [`SCH_SYNC_BITS-1:0] pin_meta;
	logic [`SCH_SYNC_BITS-1:0] pin_sync;
	logic eos_s;
	logic done_s;
	logic lnk_s;

	// Next values of the status group.
	logic next_user_reset;
	logic next_user_link_up;
	logic next_design_switch;
	logic next_eos_out;

	// Next values of the core input multiplexer and the request response.
	sch_ctrl_t next_core_ctrl;
	sch_resp_t next_rx_resp;

	// Next values of the configuration port arbitration.
	sch_arb_t arb;
	sch_arb_t next_arb;
	logic next_cap_request;

	// The user clock is the block clock itself, so interfacing logic shares this domain.
	assign user_clk = clock;

	assign pin_raw[`SCH_PIN_EOS] = eos_in;
	assign pin_raw[`SCH_PIN_DONE] = stage2_done;
	assign pin_raw[`SCH_PIN_LNK] = link_up_in;

	for (genvar i = 0; i < `SCH_SYNC_BITS; i++) begin : g_sync
		always_ff @(posedge clock) begin
			pin_meta[i] <= pin_raw[i];
			pin_sync[i] <= pin_meta[i];
		end
	end

	assign eos_s = pin_sync[`SCH_PIN_EOS];
	assign done_s = pin_sync[`SCH_PIN_DONE];
	assign lnk_s = pin_sync[`SCH_PIN_LNK];

	// Status group.
	// The hand-off flag is sticky: once both the load-complete and the startup
	// indications are seen it stays high until the next reset.
	// Requiring both keeps a stray load-complete pulse before startup from
	// releasing the multiplexers too early.
	always_comb begin
		next_user_reset = 1'b0;
		next_user_link_up = lnk_s;
		next_eos_out = eos_s;
		next_design_switch = design_switch | (done_s & eos_s);
		if (rst) begin
			next_user_reset = `SCH_RST_VAL;
			next_user_link_up = 1'b0;
			next_eos_out = 1'b0;
			next_design_switch = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		user_reset <= next_user_reset;
		user_link_up <= next_user_link_up;
		eos_out <= next_eos_out;
		design_switch <= next_design_switch;
	end

	// Multiplexer and response group.
	// Until hand-off the core sees its inputs at the idle value, so glitches from
	// absent user logic cannot reach it.
	// Unhandled requests are answered with Unsupported Request before hand-off
	// and forwarded to user logic after it; the two answers never coincide.
	always_comb begin
		next_core_ctrl = design_switch ? user_ctrl : '{ctrl: `SCH_CTRL_IDLE};
		next_rx_resp.ur = rx_req.valid & rx_req.unhandled & ~design_switch;
		next_rx_resp.fwd = rx_req.valid & rx_req.unhandled & design_switch;
		if (rst) begin
			next_core_ctrl = '{ctrl: `SCH_CTRL_IDLE};
			next_rx_resp = '0;
		end
	end

	always_ff @(posedge clock) begin
		core_ctrl <= next_core_ctrl;
		rx_resp <= next_rx_resp;
	end

	// Arbitration group.
	// A release asked for before hand-off is ignored, so the media port keeps the
	// configuration logic until the second stage is in place.
	// The drop state lasts one cycle so that the request is seen low by the
	// outside arbiter before a new request can be raised.
	always_comb begin
		next_arb = arb;
		next_cap_request = cap_request;
		unique case (arb)
			SCH_IDLE: begin
				if (cfg_want) begin
					next_arb = SCH_REQ;
					next_cap_request = 1'b1;
				end
			end
			SCH_REQ: begin
				if (cap_grant) begin
					next_arb = SCH_OWN;
				end else if (!cfg_want) begin
					next_arb = SCH_DROP;
					next_cap_request = 1'b0;
				end
			end
			SCH_OWN: begin
				if ((cap_release && design_switch) || !cfg_want) begin
					next_arb = SCH_DROP;
					next_cap_request = 1'b0;
				end
			end
			SCH_DROP: begin
				next_arb = SCH_IDLE;
				next_cap_request = 1'b0;
			end
		endcase
		if (rst) begin
			next_arb = SCH_IDLE;
			next_cap_request = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		arb <= next_arb;
		cap_request <= next_cap_request;
	end

	AST_MUX_HOLD: assert property (@(posedge clock) disable iff (rst)
		!$past(design_switch) |-> core_ctrl.ctrl == `SCH_CTRL_IDLE) else $error("core inputs not held");
	AST_MUX_PASS: assert property (@(posedge clock) disable iff (rst)
		$past(design_switch) |-> core_ctrl == $past(user_ctrl)) else $error("user inputs not passed");
	AST_UR: assert property (@(posedge clock) disable iff (rst)
		rx_req.valid && rx_req.unhandled && !design_switch |=> rx_resp.ur && !rx_resp.fwd) else $error("no UR");
	AST_FWD: assert property (@(posedge clock) disable iff (rst)
		rx_req.valid && rx_req.unhandled && design_switch |=> rx_resp.fwd && !rx_resp.ur) else $error("no fwd");
	AST_SWITCH_STICKY: assert property (@(posedge clock) disable iff (rst)
		design_switch |=> design_switch) else $error("switch dropped");
	AST_EOS: assert property (@(posedge clock) disable iff (rst)
		$rose(eos_in) ##1 eos_in[*2] |=> eos_out) else $error("eos not mirrored");
	AST_REQ: assert property (@(posedge clock) disable iff (rst)
		arb == SCH_IDLE && cfg_want |=> cap_request) else $error("no request");
	AST_REL: assert property (@(posedge clock) disable iff (rst)
		arb == SCH_OWN && cap_release && design_switch |=> !cap_request ##1 arb == SCH_IDLE) else $error("no release");
	AST_RST: assert property (@(posedge clock) rst |=> user_reset) else $error("reset not shown");
	AST_LNK: assert property (@(posedge clock) disable iff (rst)
		!link_up_in[*3] |=> !user_link_up) else $error("link up stuck");

	// Response pulses must each trace back to a request of the right phase.
	AST_UR_SRC: assert property (@(posedge clock) disable iff (rst)
		rx_resp.ur |-> $past(rx_req.valid && rx_req.unhandled && !design_switch)) else $error("stray UR");
	AST_FWD_SRC: assert property (@(posedge clock) disable iff (rst)
		rx_resp.fwd |-> $past(rx_req.valid && rx_req.unhandled && design_switch)) else $error("stray fwd");
	AST_RESP_EXCL: assert property (@(posedge clock) disable iff (rst)
		!(rx_resp.fwd && rx_resp.ur)) else $error("fwd and UR together");

	// The hand-off flag may only rise once both synchronised indications are high.
	AST_SWITCH_RISE: assert property (@(posedge clock) disable iff (rst)
		$rose(design_switch) |-> $past(done_s && eos_s)) else $error("early switch");
	AST_RST_CLR: assert property (@(posedge clock)
		rst |=> !design_switch && !cap_request) else $error("reset left state");
	AST_RST_LOW: assert property (@(posedge clock)
		!rst |=> !user_reset) else $error("reset output stuck");

	// Startup and link pass-throughs follow their pins in both directions.
	AST_EOS_LOW: assert property (@(posedge clock) disable iff (rst)
		!eos_in[*3] |=> !eos_out) else $error("eos stuck high");
	AST_LNK_UP: assert property (@(posedge clock) disable iff (rst)
		$rose(link_up_in) ##1 link_up_in[*2] |=> user_link_up) else $error("link up missed");

	// Arbitration: the request holds while owned before hand-off and drops cleanly.
	AST_REQ_HOLD: assert property (@(posedge clock) disable iff (rst)
		arb == SCH_OWN && !design_switch && cfg_want |=> cap_request) else $error("request lost");
	AST_DROP_LOW: assert property (@(posedge clock) disable iff (rst)
		arb == SCH_DROP |-> !cap_request) else $error("request high in drop");
	AST_WANT_DROP: assert property (@(posedge clock) disable iff (rst)
		arb == SCH_REQ && !cap_grant && !cfg_want |=> !cap_request) else $error("request not withdrawn");
endmodule : sch_handoff
`default_nettype wire

// *** testbench/sch_arb_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sch_arb_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic cap_request,
	input wire logic rel_ask,
	output logic cap_grant,
	output logic cap_release
);
	logic req_q;
	always_ff @(posedge clock) begin
		req_q <= !rst && cap_request;
		// Grant follows every request, as a sole-interface system tied high would.
		cap_grant <= !rst && req_q;
		// Release stays low unless the bench asks, as a sole-interface tie-off would.
		cap_release <= !rst && rel_ask && req_q;
	end
endmodule : sch_arb_model
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import sch_pkg::*;
	logic clock = 0, rst = 1, eos = 0, s2 = 0, lnk = 0, want = 0, ask = 0;
	logic rr, lu, sw, eo, cr, gnt, rel;
	sch_ctrl_t uc = '0, cc;
	sch_req_t rq = '0;
	sch_resp_t rs;
	int n_errors = 0, n_compared = 0;
	always #5 clock = ~clock;
	sch_handoff DUT (.clock(clock), .rst(rst), .eos_in(eos), .stage2_done(s2), .link_up_in(lnk),
		.cfg_want(want), .cap_grant(gnt), .cap_release(rel), .user_ctrl(uc), .rx_req(rq),
		.user_clk(), .user_reset(rr), .user_link_up(lu), .design_switch(sw), .eos_out(eo),
		.cap_request(cr), .core_ctrl(cc), .rx_resp(rs));
	sch_arb_model PM (.clock(clock), .rst(rst), .cap_request(cr), .rel_ask(ask),
		.cap_grant(gnt), .cap_release(rel));
	task chk(input string n, input logic [3:0] s, input logic [3:0] e);
		n_compared++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask : cyc
	task send;
		@(posedge clock) rq <= 2'b11;
		@(posedge clock) rq <= '0;
		#1;
	endtask : send
	task t_before;
		chk("user_reset", rr, 0);
		@(posedge clock) uc <= 4'ha;
		cyc(2);
		chk("core_ctrl", cc, 0);
		send();
		chk("rx_resp", rs, 2'b01);
		chk("design_switch", sw, 0);
		@(posedge clock) begin eos <= 1; lnk <= 1; end
		cyc(3);
		chk("eos_out", eo, 1);
		chk("user_link_up", lu, 1);
	endtask : t_before
	task t_arb_held;
		@(posedge clock) want <= 1;
		cyc(2);
		chk("cap_request", cr, 1);
		@(posedge clock) ask <= 1;
		cyc(5);
		chk("cap_request", cr, 1);
		@(posedge clock) ask <= 0;
	endtask : t_arb_held
	task t_handoff;
		@(posedge clock) s2 <= 1;
		cyc(5);
		chk("design_switch", sw, 1);
		chk("core_ctrl", cc, 4'ha);
		send();
		chk("rx_resp", rs, 2'b10);
	endtask : t_handoff
	task t_arb_release;
		@(posedge clock) ask <= 1;
		cyc(3);
		chk("cap_request", cr, 0);
		@(posedge clock) begin ask <= 0; want <= 0; rst <= 1; end
		cyc(1);
		chk("user_reset", rr, 1);
		chk("design_switch", sw, 0);
	endtask : t_arb_release
	task report_and_stop;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (3) @(posedge clock);
		rst <= 0;
		cyc(1);
		t_before();
		t_arb_held();
		t_handoff();
		t_arb_release();
		report_and_stop();
	end
	initial begin
		repeat (2000) @(posedge clock);
		n_errors++;
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
